// >>> design/mcsf_pkg.sv
// Package with build settings and carrier types of the multi-channel shared FIFO
package mcsf_pkg;
    // Build settings; each option is fixed at elaboration
    localparam int NUM_CH = 4;              // One of 1, 2, 4, 8, 16
    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int SYM_PER_BEAT = 4;        // 1 to 32
    localparam int BITS_PER_SYM = 8;        // 1 to 32
    localparam int DATA_W = SYM_PER_BEAT * BITS_PER_SYM;
    localparam int ERR_W = 1;               // 0 to 32, 0 means no error field
    localparam int EW = (ERR_W > 0) ? ERR_W : 1;
    localparam int AW = 4;                  // Segment address width, 1 to 32
    localparam int DEPTH = 2 ** AW;         // Per-channel segment depth
    localparam bit USE_PACKETS = 1'b1;
    localparam bit USE_FILL = 1'b1;
    localparam int NUM_AF = 2;              // Almost-full thresholds, 0 to 2
    localparam int NUM_AE = 2;              // Almost-empty thresholds, 0 to 2
    localparam bit PKT_BUF = 1'b1;
    localparam bit DROP_ERR = 1'b1;
    localparam bit USE_REQ = 1'b1;
    localparam int IN_FIFO_DEPTH = 8;
    // Word count that must be exceeded before a channel may deliver outside buffer mode
    localparam logic [AW:0] SECT_AVAIL = 5'h0_000;
    // Counter constants
    localparam logic [AW:0] CNT_ZERO = 5'h0_000;
    localparam logic [AW:0] CNT_ONE = 5'h0_001;
    localparam logic [AW:0] CNT_FULL = 5'h0_010;
    localparam logic [AW-1:0] PTR_ONE = 4'h0_001;
    localparam logic [CH_W-1:0] CH_ZERO = '0;
    localparam logic [CH_W-1:0] CH_ONE = 2'h0_001;

    // One stored beat
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [EW-1:0] err;
        logic sop;
        logic eop;
    } mcsf_beat_t;

    // A beat with its channel, as carried by the input buffer
    typedef struct packed {
        logic [CH_W-1:0] ch;
        mcsf_beat_t beat;
    } mcsf_in_t;

    // Round-robin threshold status word
    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] ch;
        logic [1:0] flags;
    } mcsf_stat_t;
endpackage

// >>> design/mcsf_top.sv
// Multi-channel shared-memory FIFO with input buffer, request port and status
`timescale 1ns/1ps

// Small valid/ready FIFO standing in front of the shared memory
module mcsf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    output logic [W-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam logic [PW:0] LVL_FULL = PW'(D) == '0 ? {1'b1, {PW{1'b0}}} : (PW+1)'(D);
    logic [W-1:0] mem_q [D];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] lvl_q;
    logic push;
    logic pop;
    logic ready_q;
    assign s_ready = ready_q;
    assign m_valid = (lvl_q != '0);
    assign m_data = mem_q[rd_q];
    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;

    // Storage has no reset; only the pointers, level and ready need a defined value
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= s_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            lvl_q <= '0;
            ready_q <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(D - 1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(D - 1)) ? '0 : rd_q + PW'(1);
            end
            lvl_q <= lvl_q + (PW+1)'(push) - (PW+1)'(pop);
            ready_q <= (lvl_q + (PW+1)'(push) - (PW+1)'(pop)) != LVL_FULL; // Ready is a flop
        end
    end
endmodule // mcsf_fifo

module mcsf_top (
    input wire logic ref_clk,
    input wire logic resetn,
    // Streaming sink
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [mcsf_pkg::DATA_W-1:0] in_data,
    input wire logic [mcsf_pkg::CH_W-1:0] in_channel,
    input wire logic [mcsf_pkg::EW-1:0] in_error,
    input wire logic in_sop,
    input wire logic in_eop,
    // Request port
    input wire logic req_write,
    input wire logic [mcsf_pkg::CH_W-1:0] req_address,
    output logic req_busy,
    output logic req_nodata,
    // Streaming source
    output logic out_valid,
    input wire logic out_ready,
    output logic [mcsf_pkg::DATA_W-1:0] out_data,
    output logic [mcsf_pkg::CH_W-1:0] out_channel,
    output logic [mcsf_pkg::EW-1:0] out_error,
    output logic out_sop,
    output logic out_eop,
    // Thresholds, shared by all channels
    input wire logic [mcsf_pkg::AW:0] thr_full1,
    input wire logic [mcsf_pkg::AW:0] thr_full2,
    input wire logic [mcsf_pkg::AW:0] thr_empty1,
    input wire logic [mcsf_pkg::AW:0] thr_empty2,
    // Round-robin status sources
    output logic af_valid,
    output logic [mcsf_pkg::CH_W-1:0] af_channel,
    output logic [1:0] af_data,
    output logic ae_valid,
    output logic [mcsf_pkg::CH_W-1:0] ae_channel,
    output logic [1:0] ae_data,
    // Fill-level readout, one cycle latency
    input wire logic [mcsf_pkg::CH_W-1:0] fill_channel,
    output logic [mcsf_pkg::AW:0] fill_level
);
    localparam int NUM_CH = mcsf_pkg::NUM_CH;
    localparam int CH_W = mcsf_pkg::CH_W;
    localparam int AW = mcsf_pkg::AW;
    localparam int IDX_W = CH_W + AW;
    localparam int IN_W = $bits(mcsf_pkg::mcsf_in_t);
    localparam bit PKT_ON = mcsf_pkg::USE_PACKETS;
    localparam bit BUF_ON = mcsf_pkg::USE_PACKETS && mcsf_pkg::PKT_BUF;
    localparam bit DROP_ON = BUF_ON && mcsf_pkg::DROP_ERR;
    localparam logic [mcsf_pkg::EW-1:0] ERR_MASK = (mcsf_pkg::ERR_W > 0) ? '1 : '0;

    // Delivery is allowed from committed words in buffer mode, else from the section
    function automatic logic chan_ready(input logic [AW:0] cnt, input logic [AW:0] com);
        if (BUF_ON) begin
            return com != mcsf_pkg::CNT_ZERO;
        end
        return cnt > mcsf_pkg::SECT_AVAIL;
    endfunction
    // Shared memory address of a channel's slot
    function automatic logic [IDX_W-1:0] seg_idx(input logic [CH_W-1:0] ch,
                                                  input logic [AW-1:0] ptr);
        return {ch, ptr};
    endfunction

    mcsf_pkg::mcsf_in_t in_word;
    mcsf_pkg::mcsf_in_t buf_word;
    logic buf_valid;
    logic buf_ready;
    mcsf_pkg::mcsf_beat_t mem_q [NUM_CH * mcsf_pkg::DEPTH];
    logic [AW:0] cnt_q [NUM_CH];
    logic [AW:0] cnt_d [NUM_CH];
    logic [AW:0] com_q [NUM_CH];
    logic [AW:0] com_d [NUM_CH];
    logic [AW:0] plen_q [NUM_CH];
    logic [AW:0] plen_d [NUM_CH];
    logic perr_q [NUM_CH];
    logic perr_d [NUM_CH];
    logic [AW-1:0] wptr_q [NUM_CH];
    logic [AW-1:0] wptr_d [NUM_CH];
    logic [AW-1:0] rptr_q [NUM_CH];
    logic [AW-1:0] rptr_d [NUM_CH];
    logic [CH_W-1:0] wch;
    logic wr_fire;
    logic beat_err;
    logic [CH_W-1:0] rch;
    logic rq_go;
    logic accept;
    logic hit;
    logic st1_v_q;
    logic st1_hit_q;
    logic [CH_W-1:0] st1_ch_q;
    logic [IDX_W-1:0] st1_idx_q;
    logic st2_v_q;
    logic st2_hit_q;
    logic [CH_W-1:0] st2_ch_q;
    mcsf_pkg::mcsf_beat_t st2_beat_q;
    logic [CH_W-1:0] rr_q;
    mcsf_pkg::mcsf_stat_t af_q;
    mcsf_pkg::mcsf_stat_t ae_q;

    // Incoming beats pass the buffer first; its ready is the sink's ready
    always_comb begin
        in_word.ch = (NUM_CH > 1) ? in_channel : mcsf_pkg::CH_ZERO;
        in_word.beat.data = in_data;
        in_word.beat.err = in_error & ERR_MASK;
        in_word.beat.sop = PKT_ON && in_sop;
        in_word.beat.eop = PKT_ON && in_eop;
    end

    mcsf_fifo #(
        .W(IN_W),
        .D(mcsf_pkg::IN_FIFO_DEPTH)
    ) u_in_fifo (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .s_data(in_word),
        .s_valid(in_valid),
        .s_ready(in_ready),
        .m_data(buf_word),
        .m_valid(buf_valid),
        .m_ready(buf_ready)
    );
    // A full segment stalls the buffer, which in turn stalls the sink
    assign wch = buf_word.ch;
    assign buf_ready = (cnt_q[wch] != mcsf_pkg::CNT_FULL);
    assign wr_fire = buf_valid && buf_ready;
    assign beat_err = (buf_word.beat.err != '0);
    // Without the request port the output behaves as a standing channel-0 request
    assign rch = mcsf_pkg::USE_REQ ? req_address : mcsf_pkg::CH_ZERO;
    assign rq_go = mcsf_pkg::USE_REQ ? req_write : 1'b1;
    assign accept = rq_go && !req_busy;
    assign hit = chan_ready(cnt_q[rch], com_q[rch]);
    // Next pointers and counts; a drop rewinds the write side by the packet length
    always_comb begin
        cnt_d = cnt_q;
        com_d = com_q;
        plen_d = plen_q;
        perr_d = perr_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (accept && hit) begin
            rptr_d[rch] = rptr_q[rch] + mcsf_pkg::PTR_ONE;
            cnt_d[rch] = cnt_d[rch] - mcsf_pkg::CNT_ONE;
            if (BUF_ON) begin
                com_d[rch] = com_q[rch] - mcsf_pkg::CNT_ONE;
            end
        end
        if (wr_fire) begin
            wptr_d[wch] = wptr_q[wch] + mcsf_pkg::PTR_ONE;
            cnt_d[wch] = cnt_d[wch] + mcsf_pkg::CNT_ONE;
            if (BUF_ON) begin
                if (!buf_word.beat.eop) begin
                    plen_d[wch] = plen_q[wch] + mcsf_pkg::CNT_ONE;
                    perr_d[wch] = perr_q[wch] || beat_err;
                end else if (DROP_ON && (perr_q[wch] || beat_err)) begin
                    // Uncommitted words are never read, so rewinding is safe
                    wptr_d[wch] = wptr_q[wch] - plen_q[wch][AW-1:0];
                    cnt_d[wch] = cnt_d[wch] - plen_q[wch] - mcsf_pkg::CNT_ONE;
                    plen_d[wch] = mcsf_pkg::CNT_ZERO;
                    perr_d[wch] = 1'b0;
                end else begin
                    com_d[wch] = com_d[wch] + plen_q[wch] + mcsf_pkg::CNT_ONE;
                    plen_d[wch] = mcsf_pkg::CNT_ZERO;
                    perr_d[wch] = 1'b0;
                end
            end
        end
    end
    // Per-channel bookkeeping registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cnt_q[c] <= mcsf_pkg::CNT_ZERO;
                com_q[c] <= mcsf_pkg::CNT_ZERO;
                plen_q[c] <= mcsf_pkg::CNT_ZERO;
                perr_q[c] <= 1'b0;
                wptr_q[c] <= '0;
                rptr_q[c] <= '0;
            end
        end else begin
            cnt_q <= cnt_d;
            com_q <= com_d;
            plen_q <= plen_d;
            perr_q <= perr_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end
    // Shared memory: one write port from the buffer, one registered read port
    always_ff @(posedge ref_clk) begin
        if (wr_fire) begin
            mem_q[seg_idx(wch, wptr_q[wch])] <= buf_word.beat;
        end
        st2_beat_q <= mem_q[st1_idx_q];
    end
    // Request pipeline: taken, read, presented on the third edge; only flags need reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st1_v_q <= 1'b0;
            st1_hit_q <= 1'b0;
            st2_v_q <= 1'b0;
            st2_hit_q <= 1'b0;
        end else begin
            st1_v_q <= accept;
            st1_hit_q <= hit;
            st1_ch_q <= rch;
            st1_idx_q <= seg_idx(rch, rptr_q[rch]);
            st2_v_q <= st1_v_q;
            st2_hit_q <= st1_hit_q;
            st2_ch_q <= st1_ch_q;
        end
    end
    // Source registers hold a word until it is taken; a miss leaves valid low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_data <= '0;
            out_channel <= mcsf_pkg::CH_ZERO;
            out_error <= '0;
            out_sop <= 1'b0;
            out_eop <= 1'b0;
            req_nodata <= 1'b0;
        end else begin
            req_nodata <= st2_v_q && !st2_hit_q;
            if (st2_v_q && st2_hit_q) begin
                out_valid <= 1'b1;
                out_data <= st2_beat_q.data;
                out_channel <= st2_ch_q;
                out_error <= st2_beat_q.err;
                out_sop <= st2_beat_q.sop;
                out_eop <= st2_beat_q.eop;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
    // Only one request may be outstanding; busy ends when its answer is done
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            req_busy <= 1'b0;
        end else if (accept) begin
            req_busy <= 1'b1;
        end else if ((out_valid && out_ready) || (st2_v_q && !st2_hit_q)) begin
            req_busy <= 1'b0;
        end
    end
    // Status scan visits one channel per cycle in rising order
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rr_q <= mcsf_pkg::CH_ZERO;
        end else if (rr_q == CH_W'(NUM_CH - 1)) begin
            rr_q <= mcsf_pkg::CH_ZERO;
        end else begin
            rr_q <= rr_q + mcsf_pkg::CH_ONE;
        end
    end

    // Flag 0 is the near-full/near-empty mark, flag 1 the earlier warning
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            af_q <= '0;
            ae_q <= '0;
        end else begin
            af_q.valid <= (mcsf_pkg::NUM_AF > 0);
            af_q.ch <= rr_q;
            af_q.flags[0] <= (mcsf_pkg::NUM_AF >= 1) && (cnt_q[rr_q] >= thr_full1);
            af_q.flags[1] <= (mcsf_pkg::NUM_AF >= 2) && (cnt_q[rr_q] >= thr_full2);
            ae_q.valid <= (mcsf_pkg::NUM_AE > 0);
            ae_q.ch <= rr_q;
            ae_q.flags[0] <= (mcsf_pkg::NUM_AE >= 1) && (cnt_q[rr_q] <= thr_empty1);
            ae_q.flags[1] <= (mcsf_pkg::NUM_AE >= 2) && (cnt_q[rr_q] <= thr_empty2);
        end
    end

    assign af_valid = af_q.valid;
    assign af_channel = af_q.ch;
    assign af_data = af_q.flags;
    assign ae_valid = ae_q.valid;
    assign ae_channel = ae_q.ch;
    assign ae_data = ae_q.flags;

    // Level readout is a plain register, zero when the option is off
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            fill_level <= mcsf_pkg::CNT_ZERO;
        end else begin
            fill_level <= mcsf_pkg::USE_FILL ? cnt_q[fill_channel] : mcsf_pkg::CNT_ZERO;
        end
    end
endmodule // mcsf_top

// >>> dv/mcsf_top_sva.sv
// Concurrent checks on the request, source and status ports of the shared FIFO
`timescale 1ns/1ps
module mcsf_top_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic req_write,
    input wire logic req_busy,
    input wire logic req_nodata,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [mcsf_pkg::DATA_W-1:0] out_data,
    input wire logic af_valid,
    input wire logic [mcsf_pkg::CH_W-1:0] af_channel,
    input wire logic [1:0] af_data,
    input wire logic ae_valid,
    input wire logic [mcsf_pkg::CH_W-1:0] ae_channel,
    input wire logic [1:0] ae_data,
    input wire logic [mcsf_pkg::AW:0] thr_full1,
    input wire logic [mcsf_pkg::AW:0] thr_full2,
    input wire logic [mcsf_pkg::AW:0] thr_empty1
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    logic taken;
    // A request counts only while the port is idle
    assign taken = req_write && !req_busy;
    sequence s_taken;
        taken;
    endsequence
    // Two quiet busy cycles come before the answer
    sequence s_wait;
        (req_busy && !out_valid && !req_nodata) [*2];
    endsequence
    a_req_latency: assert property (s_taken |=> s_wait ##1 (out_valid ^ req_nodata))
        else $error("answer not in third cycle");
    a_word_cause: assert property ((out_valid && !$past(out_valid)) |-> $past(taken, 3))
        else $error("word without request");
    a_word_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("word dropped before taken");
    a_busy_release: assert property (out_valid && out_ready |=> !out_valid && !req_busy)
        else $error("source not released");
    a_nodata_pulse: assert property (req_nodata |-> !req_busy ##1 (!req_nodata && !out_valid))
        else $error("nodata not one pulse");
    a_af_rotate: assert property (af_valid |=> af_valid && af_channel == $past(af_channel) + mcsf_pkg::CH_ONE)
        else $error("full status out of turn");
    a_ae_rotate: assert property (ae_valid |=> ae_valid && ae_channel == $past(ae_channel) + mcsf_pkg::CH_ONE)
        else $error("empty status out of turn");
    a_af_zero: assert property (af_valid && thr_full1 == mcsf_pkg::CNT_ZERO && $stable(thr_full1) |-> af_data[0])
        else $error("full flag low at zero");
    a_ae_top: assert property (ae_valid && thr_empty1 == mcsf_pkg::CNT_FULL && $stable(thr_empty1) |-> ae_data[0])
        else $error("empty flag low at top");
    a_af_pair: assert property (af_valid && thr_full1 == thr_full2 && $stable(thr_full1) && $stable(thr_full2)
        |-> af_data[0] == af_data[1])
        else $error("full flags disagree");
endmodule // mcsf_top_sva

bind mcsf_top mcsf_top_sva chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .req_write(req_write), .req_busy(req_busy),
    .req_nodata(req_nodata), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .af_valid(af_valid), .af_channel(af_channel), .af_data(af_data), .ae_valid(ae_valid),
    .ae_channel(ae_channel), .ae_data(ae_data), .thr_full1(thr_full1), .thr_full2(thr_full2),
    .thr_empty1(thr_empty1)
);

// >>> dv/mcsf_sink_model.sv
// Downstream consumer model that takes words promptly or with stalls
`timescale 1ns/1ps
module mcsf_sink_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slow,
    output logic out_ready
);
    logic [1:0] stall_q;
    // Slow mode is ready one cycle in four, so the source must hold its word
    always @(posedge ref_clk) begin
        if (!resetn) begin
            stall_q <= 2'h0;
            out_ready <= 1'h0;
        end else begin
            stall_q <= stall_q + 2'h1;
            out_ready <= !slow || stall_q == 2'h3;
        end
    end
endmodule // mcsf_sink_model

// >>> dv/mcsf_top_test.sv
// Self-checking bench for the multi-channel shared FIFO
`timescale 1ns/1ps
module mcsf_top_test;
    logic ref_clk = 1'h0;
    logic resetn, in_valid, in_sop, in_eop, req_write, out_ready, slow;
    logic in_ready, req_busy, req_nodata, out_valid, out_sop, out_eop, af_valid, ae_valid;
    logic [mcsf_pkg::DATA_W-1:0] in_data, out_data;
    logic [mcsf_pkg::CH_W-1:0] in_channel, req_address, out_channel, af_channel, ae_channel;
    logic [mcsf_pkg::CH_W-1:0] fill_channel;
    logic [mcsf_pkg::EW-1:0] in_error, out_error;
    logic [mcsf_pkg::AW:0] thr_full1, thr_full2, thr_empty1, thr_empty2, fill_level;
    logic [1:0] af_data, ae_data;
    int num_errors = 0;
    int checked = 0;
    mcsf_pkg::mcsf_beat_t sb[mcsf_pkg::NUM_CH][$];
    mcsf_pkg::mcsf_beat_t pend[$];

    always #20 ref_clk = ~ref_clk;

    mcsf_top dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_channel(in_channel), .in_error(in_error), .in_sop(in_sop),
        .in_eop(in_eop), .req_write(req_write), .req_address(req_address), .req_busy(req_busy),
        .req_nodata(req_nodata), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_channel(out_channel), .out_error(out_error),
        .out_sop(out_sop), .out_eop(out_eop), .thr_full1(thr_full1), .thr_full2(thr_full2),
        .thr_empty1(thr_empty1), .thr_empty2(thr_empty2), .af_valid(af_valid),
        .af_channel(af_channel), .af_data(af_data), .ae_valid(ae_valid),
        .ae_channel(ae_channel), .ae_data(ae_data), .fill_channel(fill_channel),
        .fill_level(fill_level)
    );
    mcsf_sink_model sink_u (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .out_ready(out_ready));

    task automatic complete_run();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s %h vs %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_up();
        num_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
    endtask

    // Words beyond the segment wait in the input buffer and are not counted
    function automatic int lvl(input int c);
        return (sb[c].size() > mcsf_pkg::DEPTH) ? mcsf_pkg::DEPTH : sb[c].size();
    endfunction

    // Sends beats; a packet is expected out only once closed without error
    task automatic send_pkt(input int ch, input int len, input bit bad, input bit hd, input bit tl);
        mcsf_pkg::mcsf_beat_t b;
        int n;
        for (int i = 0; i < len; i++) begin
            b.data = $urandom;
            b.err = bad && i == len - 1;
            b.sop = hd && i == 0;
            b.eop = tl && i == len - 1;
            in_valid <= 1'h1;
            in_channel <= mcsf_pkg::CH_W'(ch);
            {in_data, in_error, in_sop, in_eop} <= b;
            pend.push_back(b);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (in_ready !== 1'h1 && n < 100);
            if (n >= 100) give_up();
        end
        in_valid <= 1'h0;
        // One idle edge keeps the next call from driving valid twice in a time step
        @(posedge ref_clk);
        if (tl && !bad) sb[ch] = {sb[ch], pend};
        if (tl) pend.delete();
    endtask

    // One request; the answer is a word or a nodata pulse
    task automatic request(input int ch);
        mcsf_pkg::mcsf_beat_t b;
        int n;
        bit has;
        has = sb[ch].size() > 0;
        if (has) b = sb[ch].pop_front();
        req_write <= 1'h1;
        req_address <= mcsf_pkg::CH_W'(ch);
        @(posedge ref_clk);
        req_write <= 1'h0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (out_valid !== 1'h1 && req_nodata !== 1'h1 && n < 20);
        if (n >= 20) give_up();
        check(n, 3, "answer latency");
        check(req_nodata, !has, "nodata");
        n = 0;
        while (has && !(out_valid === 1'h1 && out_ready === 1'h1) && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40) give_up();
        if (has) check({out_data, out_error, out_sop, out_eop, out_channel},
            {b, mcsf_pkg::CH_W'(ch)}, "word");
    endtask

    task automatic check_fill();
        for (int c = 0; c < mcsf_pkg::NUM_CH; c++) begin
            fill_channel <= mcsf_pkg::CH_W'(c);
            repeat (2) @(posedge ref_clk);
            check(fill_level, lvl(c), "fill level");
        end
    endtask

    task automatic check_status();
        repeat (8) begin
            @(posedge ref_clk);
            check(af_data, {lvl(af_channel) >= thr_full2, lvl(af_channel) >= thr_full1}, "af");
            check(ae_data, {lvl(ae_channel) <= thr_empty2, lvl(ae_channel) <= thr_empty1}, "ae");
        end
    endtask

    initial begin
        int r;
        void'($urandom(5));
        {resetn, in_valid, in_sop, in_eop, req_write, slow, in_error} = '0;
        {in_data, in_channel, req_address, fill_channel} = '0;
        {thr_full1, thr_full2, thr_empty1, thr_empty2} = '0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'h1;
        repeat (2) @(posedge ref_clk);
        check({in_ready, af_valid, ae_valid, out_valid}, 4'he, "after reset");
        request(0);
        // Random packets, some errored and so dropped
        repeat (7) send_pkt($urandom % 4, 1 + $urandom % 2, ($urandom % 4) == 0, 1, 1);
        repeat (10) @(posedge ref_clk);
        check_fill();
        // Threshold sweep: zero, top, equal pair, random
        for (int k = 0; k < 4; k++) begin
            r = $urandom % 17;
            thr_full1 <= (k == 0) ? '0 : 5'(r);
            thr_full2 <= 5'((k == 2) ? r : $urandom % 17);
            thr_empty1 <= (k == 1) ? mcsf_pkg::CNT_FULL : 5'($urandom % 17);
            thr_empty2 <= 5'($urandom % 17);
            @(posedge ref_clk);
            check_status();
        end
        for (int c = 0; c < mcsf_pkg::NUM_CH; c++) begin
            slow <= c[0];
            repeat (sb[c].size() + 1) request(c);
        end
        // Open packet stays hidden until its end arrives
        send_pkt(2, 2, 0, 1, 0);
        request(2);
        send_pkt(2, 1, 0, 0, 1);
        repeat (5) @(posedge ref_clk);
        repeat (4) request(2);
        // Full segment backs up the input buffer until it refuses
        send_pkt(3, 16, 0, 1, 1);
        repeat (10) @(posedge ref_clk);
        repeat (8) send_pkt(3, 1, 0, 1, 1);
        repeat (4) @(posedge ref_clk);
        check(in_ready, 1'h0, "buffer full");
        check_fill();
        check_status();
        slow <= 1'h1;
        repeat (sb[3].size() + 1) request(3);
        complete_run();
    end
endmodule // mcsf_top_test
